// *** verilog/xfer_ctrl_pkg.sv ***
// package: register map, field layout, reset values and modes of the activation block
package xfer_ctrl_pkg;
  // enable bank geometry
  localparam int NUM_ENABLE_REGS = 8; // eight activation enable registers
  localparam int ENABLE_WIDTH = 16; // one bit per interrupt source
  // word index of each register (byte address = index * 4)
  localparam logic [5:0] OFS_ENABLE_BASE = 6'h00; // enable regs at indices 0..7
  localparam logic [5:0] OFS_CONTROL = 6'h08; // transfer control register
  localparam logic [5:0] OFS_STATUS = 6'h09; // activation status, read only
  // control register fields
  localparam int CTRL_STOP_BIT = 0; // transfer-stop flag
  localparam int CTRL_CHAIN_REP_BIT = 3; // chain after repeat enable
  localparam int CTRL_SKIP_BIT = 4; // info read skip enable
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  // status register fields
  localparam int STAT_ACTIVE_BIT = 0; // activation in progress
  localparam int STAT_CHAIN_BIT = 1; // previous activation used chaining
  localparam int STAT_VALID_BIT = 2; // a previous vector is held
  localparam int STAT_VECTOR_LSB = 8; // previous vector number
  // transfer modes as given with the transfer information
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_BLOCK = 2'h2;
  // activation state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_NOTIFY = 3'b100
  } act_state_e;
endpackage

// *** verilog/activation_enable_bank.sv ***
// module: bank of activation enable registers with read-then-write-zero clearing
module activation_enable_bank
  import xfer_ctrl_pkg::*;
#(
  parameter int NREG = NUM_ENABLE_REGS,
  parameter int W = ENABLE_WIDTH
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [NREG-1:0] wrStrobe,
  input wire logic [W-1:0] wrData,
  input wire logic [W-1:0] wrMask,
  input wire logic [NREG-1:0] rdStrobe,
  input wire logic [NREG*W-1:0] hwClear,
  output logic [NREG*W-1:0] enables
);
  // refuse shapes the bus lanes cannot carry
  if (W > 32 || W < 1 || NREG < 1)
  begin : gBadShape
    $error("enable bank shape not supported");
  end

  // one register and its read-arm bits per bank entry
  for (genvar r = 0; r < NREG; r++)
  begin : gReg
    logic [W-1:0] armed_reg; // bits seen as 1 by the last read
    logic [W-1:0] row;
    assign row = enables[r*W +: W];

    // arm bits on read, disarm bits touched by a write
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        armed_reg <= '0;
      else if (ce)
      begin
        if (rdStrobe[r])
          armed_reg <= row;
        else if (wrStrobe[r])
          armed_reg <= armed_reg & ~wrMask;
      end
    end

    // software set/clear, then hardware clear wins over everything
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        enables[r*W +: W] <= ENABLE_RESET[W-1:0];
      else if (ce)
      begin
        if (wrStrobe[r])
          enables[r*W +: W] <= ((row | (wrMask & wrData)) & ~(wrMask & ~wrData & armed_reg))
                               & ~hwClear[r*W +: W];
        else
          enables[r*W +: W] <= row & ~hwClear[r*W +: W];
      end
    end
  end
endmodule

// *** verilog/transfer_ctrl_activation_block_count.sv ***
// module: activation select, transfer counters, control register and stop flag
// How it works
// - block mode decrements 16-bit block counter per transfer
// - at zero, clear enable bit, then raise irq
// - count zero means 65536, one means one
// - block counter only in block mode, no access
// - eight 16-bit enable registers, reset to zero
// - enabled source activates, disabled goes to cpu
// - enable bit cleared by write 0 after read 1
// - per-transfer irq select clears enable each transfer
// - completed count clears the enable bit
// - enable kept when count open and select 0
// - control bits 7..5 and 2..1 read zero
// - compare vector with previous activation vector
// - match plus skip enable starts without info fetch
// - previous chain always forces info fetch
// - repeat reload allows chain only if enabled
// - stop flag resets 0, only writable to 0
// - address error or nmi sets stop and halts
// - irq per transfer or at count completion
// - repeat low counter reloads from high at zero
//
// Design decisions made here: register access over Wishbone and the register offsets.
module transfer_ctrl_activation_block_count
  import xfer_ctrl_pkg::*;
#(
  parameter int NREG = NUM_ENABLE_REGS,
  parameter int W = ENABLE_WIDTH
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic [NREG*W-1:0] irqSrc,
  input wire logic nmiPin,
  input wire logic addrErr,
  input wire logic infoValid,
  input wire logic [1:0] infoMode,
  input wire logic infoIrqSel,
  input wire logic infoChain,
  input wire logic [15:0] infoCountA,
  input wire logic [15:0] infoBlockCount,
  input wire logic xferDone,
  output logic [NREG*W-1:0] cpuIrq,
  output logic actReq,
  output logic [$clog2(NREG*W)-1:0] actVector,
  output logic actSkipInfo,
  output logic chainGo,
  output logic xferIrqReq,
  output logic [$clog2(NREG*W)-1:0] xferIrqVector,
  output logic halted
);
  localparam int NSRC = NREG * W; // total interrupt sources
  localparam int VW = $clog2(NSRC); // vector number width

  // refuse a bank the address decode cannot reach
  if (NREG > 8 || NSRC < 2)
  begin : gBadShape
    $error("source count not supported");
  end

  // bus slave state
  logic ack_reg; // one-cycle acknowledge
  logic [31:0] rdat_reg; // read data held with ack
  logic busReq; // new access this cycle
  logic [5:0] wordIdx; // word index of the access
  logic [W-1:0] byteMask; // write mask from byte selects

  // control register bits
  logic skipEn_reg; // info_read_skip_en
  logic chainRepEn_reg; // chain_after_repeat_en
  logic stop_reg; // transfer-stop flag
  logic stopArmed_reg; // stop read as 1 since last write
  logic nmiMeta_reg; // first synchroniser stage
  logic nmiSync_reg; // second synchroniser stage

  // activation state
  act_state_e state_reg;
  logic [VW-1:0] curSrc_reg; // source being served
  logic [VW-1:0] lastVec_reg; // previous activation vector
  logic lastValid_reg; // previous vector is meaningful
  logic lastChain_reg; // previous activation chained
  logic curChain_reg; // this activation chained so far

  // transfer information held for the activation
  logic [1:0] mode_reg; // normal, repeat or block
  logic irqSel_reg; // per_transfer_irq_sel
  logic chain_reg; // next transfer is chained
  logic [15:0] countA_reg; // normal count or repeat halves
  logic [15:0] blockCount_reg; // block_count_reg

  // bank wiring
  logic [NSRC-1:0] enables;
  logic [NSRC-1:0] hwClear;
  logic [NREG-1:0] bankWr;
  logic [NREG-1:0] bankRd;

  // transfer decisions
  logic pendAny; // an enabled source is requesting
  logic [VW-1:0] pendIdx; // lowest such source
  logic countDone; // programmed count reached zero
  logic reload; // repeat low half reloads now
  logic chainNow; // continue with a chained transfer
  logic endNow; // activation finishes this cycle
  logic clearSrc; // clear the source enable at the end
  logic stopEvt; // address error or nmi

  assign busReq = wbCyc && wbStb && !ack_reg;
  assign wordIdx = wbAdr[7:2];
  assign stopEvt = addrErr || nmiSync_reg;

  // expand byte selects to the enable register width
  always_comb
  begin
    for (int b = 0; b < W; b++)
      byteMask[b] = wbSel[b / 8];
  end

  // strobes into the enable bank
  always_comb
  begin
    bankWr = '0;
    bankRd = '0;
    for (int r = 0; r < NREG; r++)
    begin
      if (busReq && wordIdx == OFS_ENABLE_BASE + 6'(r))
      begin
        bankWr[r] = wbWe;
        bankRd[r] = !wbWe;
      end
    end
  end

  activation_enable_bank #(
    .NREG(NREG),
    .W(W)
  ) uBank (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .wrStrobe(bankWr),
    .wrData(wbDatW[W-1:0]),
    .wrMask(byteMask),
    .rdStrobe(bankRd),
    .hwClear(hwClear),
    .enables(enables)
  );

  // two-stage synchroniser for the nmi pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nmiMeta_reg <= 1'b0;
      nmiSync_reg <= 1'b0;
    end
    else if (ce)
    begin
      nmiMeta_reg <= nmiPin;
      nmiSync_reg <= nmiMeta_reg;
    end
  end

  // wishbone acknowledge and read data
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_reg <= busReq; // unmapped words also answer, reading zero
      rdat_reg <= 32'h0000_0000;
      if (busReq && !wbWe)
      begin
        if (wordIdx < OFS_ENABLE_BASE + 6'(NREG))
          rdat_reg[W-1:0] <= enables[wordIdx[2:0]*W +: W];
        else if (wordIdx == OFS_CONTROL)
        begin
          // bits 7..5, 2 and 1 stay zero
          rdat_reg[CTRL_SKIP_BIT] <= skipEn_reg;
          rdat_reg[CTRL_CHAIN_REP_BIT] <= chainRepEn_reg;
          rdat_reg[CTRL_STOP_BIT] <= stop_reg;
        end
        else if (wordIdx == OFS_STATUS)
        begin
          // shows block state, never the counters
          rdat_reg[STAT_ACTIVE_BIT] <= state_reg != ST_IDLE;
          rdat_reg[STAT_CHAIN_BIT] <= lastChain_reg;
          rdat_reg[STAT_VALID_BIT] <= lastValid_reg;
          rdat_reg[STAT_VECTOR_LSB +: VW] <= lastVec_reg;
        end
      end
    end
  end

  assign wbAck = ack_reg;
  assign wbDatR = rdat_reg;

  // control register option bits, reserved bits discard writes
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      skipEn_reg <= CTRL_RESET[CTRL_SKIP_BIT];
      chainRepEn_reg <= CTRL_RESET[CTRL_CHAIN_REP_BIT];
    end
    else if (ce && busReq && wbWe && wordIdx == OFS_CONTROL && wbSel[0])
    begin
      skipEn_reg <= wbDatW[CTRL_SKIP_BIT];
      chainRepEn_reg <= wbDatW[CTRL_CHAIN_REP_BIT];
    end
  end

  // transfer-stop flag: hardware set wins, software may only clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stop_reg <= CTRL_RESET[CTRL_STOP_BIT];
      stopArmed_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (stopEvt)
        stop_reg <= 1'b1;
      else if (busReq && wbWe && wordIdx == OFS_CONTROL && wbSel[0]
               && !wbDatW[CTRL_STOP_BIT] && stopArmed_reg)
        stop_reg <= 1'b0;
      // arm on a read that shows 1, disarm on any control write
      if (busReq && wordIdx == OFS_CONTROL)
        stopArmed_reg <= wbWe ? 1'b0 : stop_reg;
    end
  end

  assign halted = stop_reg;

  // lowest-numbered enabled source that is requesting
  always_comb
  begin
    pendAny = 1'b0;
    pendIdx = '0;
    for (int s = NSRC - 1; s >= 0; s--)
    begin
      if (irqSrc[s] && enables[s])
      begin
        pendAny = 1'b1;
        pendIdx = VW'(s);
      end
    end
  end

  // count completion, repeat reload and chain decision for this transfer
  always_comb
  begin
    countDone = 1'b0;
    reload = 1'b0;
    unique case (mode_reg)
      MODE_BLOCK: countDone = blockCount_reg == 16'h0001;
      MODE_REPEAT: reload = countA_reg[7:0] == 8'h01;
      default: countDone = countA_reg == 16'h0001;
    endcase
    // repeat reload only chains when the option allows it
    chainNow = chain_reg && (!reload || chainRepEn_reg);
    endNow = xferDone && !chainNow;
    // completion check skipped while chaining
    clearSrc = irqSel_reg || countDone;
  end

  // clear the served source enable as the activation ends
  always_comb
  begin
    hwClear = '0;
    if (state_reg == ST_ACTIVE && endNow && clearSrc && !stopEvt)
      hwClear[curSrc_reg] = 1'b1;
  end

  // counters: loaded with the transfer information, stepped per transfer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg <= MODE_NORMAL;
      irqSel_reg <= 1'b0;
      chain_reg <= 1'b0;
      countA_reg <= 16'h0000;
      blockCount_reg <= 16'h0000;
    end
    else if (ce && state_reg == ST_ACTIVE)
    begin
      if (infoValid)
      begin
        mode_reg <= infoMode;
        irqSel_reg <= infoIrqSel;
        chain_reg <= infoChain;
        countA_reg <= infoCountA;
        blockCount_reg <= infoBlockCount;
      end
      else if (xferDone)
      begin
        unique case (mode_reg)
          MODE_BLOCK: blockCount_reg <= blockCount_reg - 16'h0001;
          MODE_REPEAT:
          begin
            if (reload)
              countA_reg[7:0] <= countA_reg[15:8];
            else
              countA_reg[7:0] <= countA_reg[7:0] - 8'h01;
          end
          default: countA_reg <= countA_reg - 16'h0001;
        endcase
      end
    end
  end

  // activation state machine
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
      curSrc_reg <= '0;
      curChain_reg <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (pendAny && !stop_reg && !stopEvt)
          begin
            state_reg <= ST_ACTIVE;
            curSrc_reg <= pendIdx;
            curChain_reg <= 1'b0;
          end
        end
        ST_ACTIVE:
        begin
          if (stopEvt)
            state_reg <= ST_IDLE;
          else if (xferDone && chainNow)
            curChain_reg <= 1'b1;
          else if (endNow)
            state_reg <= clearSrc ? ST_NOTIFY : ST_IDLE;
        end
        ST_NOTIFY: state_reg <= ST_IDLE; // irq one cycle after the clear
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // previous activation memory for the read-skip decision
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lastVec_reg <= '0;
      lastValid_reg <= 1'b0;
      lastChain_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (state_reg == ST_IDLE && pendAny && !stop_reg && !stopEvt)
      begin
        lastVec_reg <= pendIdx;
        lastValid_reg <= 1'b1;
      end
      if (state_reg == ST_ACTIVE && (endNow || stopEvt))
        lastChain_reg <= curChain_reg;
    end
  end

  // activation request with skip decision, chain and irq pulses
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      actReq <= 1'b0;
      actVector <= '0;
      actSkipInfo <= 1'b0;
      chainGo <= 1'b0;
      xferIrqReq <= 1'b0;
      xferIrqVector <= '0;
    end
    else if (ce)
    begin
      actReq <= 1'b0;
      chainGo <= 1'b0;
      xferIrqReq <= 1'b0;
      if (state_reg == ST_IDLE && pendAny && !stop_reg && !stopEvt)
      begin
        actReq <= 1'b1;
        actVector <= pendIdx;
        // same vector, skip enabled and no chain last time
        actSkipInfo <= skipEn_reg && lastValid_reg && pendIdx == lastVec_reg
                       && !lastChain_reg;
      end
      if (state_reg == ST_ACTIVE && xferDone && chainNow && !stopEvt)
        chainGo <= 1'b1;
      if (state_reg == ST_NOTIFY)
      begin
        xferIrqReq <= 1'b1;
        xferIrqVector <= curSrc_reg;
      end
    end
  end

  // sources not enabled for activation pass on as cpu interrupts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cpuIrq <= '0;
    else if (ce)
      cpuIrq <= irqSrc & ~enables;
  end
endmodule

// *** verif/xfer_ctrl_props.sv ***
// checker: bus, activation, interrupt and stop-flag relations seen at the top ports
module xfer_ctrl_props
  import xfer_ctrl_pkg::*;
#(
  parameter int NREG = NUM_ENABLE_REGS,
  parameter int W = ENABLE_WIDTH
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire logic [NREG*W-1:0] irqSrc,
  input wire logic addrErr,
  input wire logic [NREG*W-1:0] cpuIrq,
  input wire logic actReq,
  input wire logic [$clog2(NREG*W)-1:0] actVector,
  input wire logic xferDone,
  input wire logic xferIrqReq,
  input wire logic [$clog2(NREG*W)-1:0] xferIrqVector,
  input wire logic halted
);
  logic ctrlRead; // software read of the control register
  logic ctrlClear; // software write of zero to the stop flag
  assign ctrlRead = wbCyc && wbStb && !wbWe && (wbAdr[7:2] == OFS_CONTROL);
  assign ctrlClear = wbCyc && wbStb && wbWe && (wbAdr[7:2] == OFS_CONTROL) && !wbDatW[CTRL_STOP_BIT];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // request taken, then a one-cycle answer
  sequence s_busReq; wbCyc && wbStb && !wbAck && ce; endsequence
  sequence s_ackBeat; wbAck ##1 !wbAck; endsequence
  property p_ackOnce; s_busReq |=> s_ackBeat; endproperty
  a_ackOnce: assert property (p_ackOnce) else $error("bus request without one-cycle ack");
  property p_readIdle; !wbAck |-> wbDatR == 32'h0; endproperty
  a_readIdle: assert property (p_readIdle) else $error("read data outside ack");
  property p_ctrlReserved; wbAck && $past(ctrlRead) |-> wbDatR[31:5] == 27'h0 && wbDatR[2:1] == 2'h0; endproperty
  a_ctrlReserved: assert property (p_ctrlReserved) else $error("control reserved bits not zero");
  property p_cpuIrqCause; (cpuIrq & ~$past(irqSrc)) == '0; endproperty
  a_cpuIrqCause: assert property (p_cpuIrqCause) else $error("cpu irq without source");
  property p_stopSets; addrErr |-> ##[1:2] halted; endproperty
  a_stopSets: assert property (p_stopSets) else $error("address error did not set stop flag");
  property p_haltBlocks; halted && $past(halted) |-> !actReq; endproperty
  a_haltBlocks: assert property (p_haltBlocks) else $error("activation while halted");
  property p_haltFall; $fell(halted) |-> $past(ctrlClear) || $past(ctrlClear, 2); endproperty
  a_haltFall: assert property (p_haltFall) else $error("stop flag cleared without write");
  property p_irqAfterDone; xferIrqReq |-> $past(xferDone, 2); endproperty
  a_irqAfterDone: assert property (p_irqAfterDone) else $error("irq not two cycles after done");
  property p_actVecHeld; !actReq |-> $stable(actVector); endproperty
  a_actVecHeld: assert property (p_actVecHeld) else $error("activation vector moved");
  property p_irqVecHeld; !xferIrqReq |-> $stable(xferIrqVector); endproperty
  a_irqVecHeld: assert property (p_irqVecHeld) else $error("irq vector moved");
endmodule

bind transfer_ctrl_activation_block_count xfer_ctrl_props #(.NREG(NREG), .W(W)) i_props (
  .clk(clk), .arst_n(arst_n), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
  .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .irqSrc(irqSrc), .addrErr(addrErr), .cpuIrq(cpuIrq),
  .actReq(actReq), .actVector(actVector), .xferDone(xferDone), .xferIrqReq(xferIrqReq),
  .xferIrqVector(xferIrqVector), .halted(halted));

// *** verif/xfer_engine_model.sv ***
// partner: transfer engine answering activations with information beats and done pulses
module xfer_engine_model
  import xfer_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic actReq,
  input wire logic actSkipInfo,
  input wire logic chainGo,
  input wire logic [1:0] cfgMode,
  input wire logic cfgIrqSel,
  input wire logic cfgChain,
  input wire logic [15:0] cfgCountA,
  input wire logic [15:0] cfgBlock,
  output logic infoValid = 1'b0,
  output logic [1:0] infoMode = 2'h0,
  output logic infoIrqSel = 1'b0,
  output logic infoChain = 1'b0,
  output logic [15:0] infoCountA = 16'h0,
  output logic [15:0] infoBlockCount = 16'h0,
  output logic xferDone = 1'b0,
  output logic busy = 1'b0
);
  logic chained; // chain follow-on granted
  // one information beat unless skipped, then one done pulse
  task automatic transfer(input logic skip, input logic chain);
    if (!skip)
    begin
      infoValid <= 1'b1;
      {infoMode, infoIrqSel, infoChain} <= {cfgMode, cfgIrqSel, chain};
      {infoCountA, infoBlockCount} <= {cfgCountA, cfgBlock};
      @(posedge clk);
      infoValid <= 1'b0;
      // fields no longer qualified: drive the inverse
      {infoMode, infoIrqSel, infoChain} <= ~{cfgMode, cfgIrqSel, chain};
      {infoCountA, infoBlockCount} <= ~{cfgCountA, cfgBlock};
    end
    xferDone <= 1'b1;
    @(posedge clk);
    xferDone <= 1'b0;
  endtask
  // answer each activation; follow a granted chain with a second transfer
  always
  begin
    @(posedge clk);
    if (actReq === 1'b1)
    begin
      busy <= 1'b1;
      transfer(actSkipInfo, cfgChain);
      chained = 1'b0;
      repeat (3)
      begin
        @(posedge clk);
        chained = chained | (chainGo === 1'b1);
      end
      if (chained)
        transfer(1'b0, 1'b0);
      busy <= 1'b0;
    end
  end
endmodule

// *** verif/tb_transfer_ctrl_activation_block_count.sv ***
// testbench: registers, cpu path, block count, per-transfer irq, chain, skip and stop flag
module tb_transfer_ctrl_activation_block_count
  import xfer_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CTRL_ADR = {OFS_CONTROL, 2'b00}; // control byte address
  logic clk = 1'b0, arst_n = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, nmiPin = 1'b0, addrErr = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, q;
  logic [127:0] irqSrc = 128'h0, cpuIrq;
  logic wbAck, actReq, actSkipInfo, chainGo, xferIrqReq, halted;
  logic [6:0] actVector, xferIrqVector;
  logic infoValid, infoIrqSel, infoChain, xferDone, busy;
  logic [1:0] infoMode, cfgMode = MODE_NORMAL;
  logic [15:0] infoCountA, infoBlockCount, cfgCountA = 16'h0, cfgBlock = 16'h0;
  logic cfgIrqSel = 1'b0, cfgChain = 1'b0;
  int errors = 0, n_tests = 0, nAct = 0, nIrq = 0, nChain = 0;
  transfer_ctrl_activation_block_count i_dut (.clk(clk), .arst_n(arst_n), .ce(1'b1), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
    .irqSrc(irqSrc), .nmiPin(nmiPin), .addrErr(addrErr), .infoValid(infoValid), .infoMode(infoMode),
    .infoIrqSel(infoIrqSel), .infoChain(infoChain), .infoCountA(infoCountA), .infoBlockCount(infoBlockCount),
    .xferDone(xferDone), .cpuIrq(cpuIrq), .actReq(actReq), .actVector(actVector), .actSkipInfo(actSkipInfo),
    .chainGo(chainGo), .xferIrqReq(xferIrqReq), .xferIrqVector(xferIrqVector), .halted(halted));
  xfer_engine_model i_engine (.clk(clk), .actReq(actReq), .actSkipInfo(actSkipInfo), .chainGo(chainGo),
    .cfgMode(cfgMode), .cfgIrqSel(cfgIrqSel), .cfgChain(cfgChain), .cfgCountA(cfgCountA), .cfgBlock(cfgBlock),
    .infoValid(infoValid), .infoMode(infoMode), .infoIrqSel(infoIrqSel), .infoChain(infoChain),
    .infoCountA(infoCountA), .infoBlockCount(infoBlockCount), .xferDone(xferDone), .busy(busy));
  initial forever #5 clk = ~clk;
  // count activation, irq and chain pulses
  always @(posedge clk)
  begin
    nAct <= nAct + int'(actReq === 1'b1);
    nIrq <= nIrq + int'(xferIrqReq === 1'b1);
    nChain <= nChain + int'(chainGo === 1'b1);
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // a wait that ran out ends the run
  task automatic expire(input logic bad);
    if (bad)
    begin
      errors++;
      report_and_stop();
    end
  endtask
  // one classic cycle; holds the request until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatW} <= {1'b1, 1'b1, we, 4'hf, a, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    q = wbDatR;
    expire(n >= 20);
    {wbCyc, wbStb} <= 2'b00;
    @(posedge clk);
  endtask
  // raise source s, judge the activation, then the irq count, chain count and enable bits
  task automatic act(input int s, input logic skip, input int irqs, input int chains, input logic [15:0] en);
    int i, a0, c0, r0;
    {a0, c0, r0} = {nAct, nChain, nIrq};
    irqSrc[s] <= 1'b1;
    for (i = 0; i < 20 && nAct == a0; i++)
      @(posedge clk);
    irqSrc[s] <= 1'b0;
    expire(nAct == a0);
    chk({25'h0, actVector}, s);
    chk({31'h0, actSkipInfo}, {31'h0, skip});
    for (i = 0; i < 40 && busy === 1'b1; i++)
      @(posedge clk);
    expire(busy === 1'b1);
    repeat (4) @(posedge clk);
    chk(nIrq - r0, irqs);
    if (irqs > 0)
      chk({25'h0, xferIrqVector}, s);
    chk(nChain - c0, chains);
    bus(1'b0, 8'(s / 16 * 4), 32'h0);
    chk(q, {16'h0, en});
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk(q, {16'h0, ENABLE_RESET});
    end
    bus(1'b0, CTRL_ADR, 32'h0);
    chk(q, {24'h0, CTRL_RESET});
    bus(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, CTRL_ADR, 32'hff);
    bus(1'b0, CTRL_ADR, 32'h0);
    chk(q, 32'h18);
    bus(1'b0, 8'h1c, 32'h0);
    bus(1'b1, 8'h1c, 32'ha5c3);
    bus(1'b1, 8'h1c, 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    chk(q, 32'ha5c3);
    bus(1'b1, 8'h1c, 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, CTRL_ADR, 32'h0);
    $display("register test done");
  endtask
  task automatic t_cpuPath();
    irqSrc[40] <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, cpuIrq[40]}, 32'h1);
    chk(nAct, 0);
    irqSrc[40] <= 1'b0;
    $display("cpu path test done");
  endtask
  task automatic t_blockCount();
    {cfgMode, cfgBlock} <= {MODE_BLOCK, 16'h0001};
    bus(1'b1, 8'h00, 32'h20);
    act(5, 1'b0, 1, 0, 16'h0000);
    cfgBlock <= 16'h0000;
    bus(1'b1, 8'h00, 32'h20);
    act(5, 1'b0, 0, 0, 16'h0020);
    cfgBlock <= 16'h0002;
    act(5, 1'b0, 0, 0, 16'h0020);
    bus(1'b1, CTRL_ADR, 32'h10);
    act(5, 1'b1, 1, 0, 16'h0000);
    $display("block count test done");
  endtask
  task automatic t_perTransfer();
    {cfgMode, cfgIrqSel, cfgCountA} <= {MODE_NORMAL, 1'b1, 16'h0005};
    bus(1'b1, CTRL_ADR, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    act(16, 1'b0, 1, 0, 16'h0000);
    cfgIrqSel <= 1'b0;
    bus(1'b1, 8'h04, 32'h1);
    act(16, 1'b0, 0, 0, 16'h0001);
    bus(1'b1, 8'h04, 32'h0);
    $display("per-transfer irq test done");
  endtask
  task automatic t_chain();
    {cfgMode, cfgChain, cfgCountA} <= {MODE_REPEAT, 1'b1, 16'h0302};
    bus(1'b1, 8'h04, 32'h2);
    act(17, 1'b0, 0, 1, 16'h0002);
    cfgCountA <= 16'h0301;
    act(17, 1'b0, 0, 0, 16'h0002);
    bus(1'b1, CTRL_ADR, 32'h08);
    act(17, 1'b0, 0, 1, 16'h0002);
    bus(1'b1, CTRL_ADR, 32'h18);
    act(17, 1'b0, 0, 1, 16'h0002);
    bus(1'b0, 8'h24, 32'h0);
    chk(q, 32'h1106);
    bus(1'b1, 8'h04, 32'h0);
    cfgChain <= 1'b0;
    $display("chain test done");
  endtask
  task automatic t_stop();
    int a0;
    bus(1'b1, 8'h00, 32'h20);
    addrErr <= 1'b1;
    @(posedge clk);
    addrErr <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, halted}, 32'h1);
    bus(1'b1, CTRL_ADR, 32'h0);
    chk({31'h0, halted}, 32'h1);
    a0 = nAct;
    irqSrc[5] <= 1'b1;
    repeat (6) @(posedge clk);
    chk(nAct - a0, 0);
    irqSrc[5] <= 1'b0;
    bus(1'b0, CTRL_ADR, 32'h0);
    chk(q, 32'h1);
    bus(1'b1, CTRL_ADR, 32'h0);
    chk({31'h0, halted}, 32'h0);
    nmiPin <= 1'b1;
    repeat (4) @(posedge clk);
    nmiPin <= 1'b0;
    repeat (4) @(posedge clk);
    chk({31'h0, halted}, 32'h1);
    $display("stop flag test done");
  endtask
  // reset, scenarios, verdict
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cpuPath();
    t_blockCount();
    t_perTransfer();
    t_chain();
    t_stop();
    report_and_stop();
  end
endmodule
